// ==== rtl/front_switch_config_decoder.sv ====
// Purpose: decode the front panel switches and apply their effects
// Assumes: all status inputs synchronous to hclk; AHB-Lite single slave
// Notes: zero wait state slave, every answer OKAY
//
// Operation
// R1: switch 1 on rejects tool writes to program, read-only data and setup words.
// R2: switch 2 on copies program, data, setup and expansion info at startup.
// R3: with auto copy and switch 4 off, skip expansion info, use defaults.
// R4: switch 3 on selects English console text, off the ROM language.
// R5: switch 4 on uses user codes; off at power-up restores defaults.
// R6: switch 5 on gives both ports the fixed standard framing at 9600 baud.
// R7: with switch 7 off, switch 5 does not affect the peripheral port.
// R8: switch 5 off takes port settings from setup words 6650 and 6645.
// R9: switch 6 is mirrored into auxiliary area bit 0712.
// R10: switch 7 off allows only the console, on allows other tools.
// R11: switch 8 enables the protocol tool; turn off before online work.
// R12: the right code in setup word 6655 bits 12-15 masks battery errors.
// R13: a dead battery clears retained areas and spoils special area at power-off.
// R14: user program clears hold and output-off bits when battery is bad.
// R15: without battery, do not keep hold bits via setup word 6601.
// R16: hold bit keeps I/O memory over mode changes; fatal stop forces outputs off.
// R17: switches sampled once after reset and held until power cycles.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module front_switch_config_decoder #(
  parameter int SETTLE_CYCLES = 16,
  parameter logic [3:0] BATT_OFF_CODE = 4'h1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [7:0] sw,
  input wire logic pd_wr_req,
  input wire front_cfg_pkg::area_e pd_wr_area,
  input wire logic xfer_ack,
  input wire logic batt_expired,
  input wire logic pwr_off,
  input wire logic mode_change,
  input wire logic fatal_stop,
  input wire logic io_hold,
  output front_cfg_pkg::cfg_s cfg_r,
  output logic cfg_valid_r,
  output logic pd_wr_ok_r,
  output logic pd_wr_rej_r,
  output logic xfer_req_r,
  output front_cfg_pkg::seg_e xfer_seg_r,
  output logic exp_default_r,
  output front_cfg_pkg::port_s periph_r,
  output front_cfg_pkg::port_s rs232_r,
  output logic batt_err_r,
  output logic retain_clear_r,
  output logic special_undef_r,
  output logic io_clear_r,
  output logic outputs_off_r,
  output logic irq_r
);

  localparam int AW = front_cfg_pkg::ADDR_LSB_W;

  logic [7:0] sw_cap;
  logic xfer_done;
  logic wr_pend_r;
  logic [AW-1:0] wr_addr_r;
  logic [front_cfg_pkg::SETUP_W-1:0] setup_r;
  logic [front_cfg_pkg::IRQ_W-1:0] irq_stat_r;
  logic [front_cfg_pkg::IRQ_W-1:0] irq_mask_r;
  logic [front_cfg_pkg::IRQ_W-1:0] irq_ev;
  logic [front_cfg_pkg::IRQ_W-1:0] irq_clr;
  logic batt_err_nxt;
  logic addr_ok;

  // ************************************************
  // switch capture and transfer sequence
  // ************************************************
  sw_sampler #(
    .W(front_cfg_pkg::SW_W),
    .SETTLE(SETTLE_CYCLES)
  ) u_sampler (
    .hclk(hclk),
    .hresetn(hresetn),
    .sw_in(sw),
    .sw_out_r(sw_cap),
    .valid_r(cfg_valid_r)
  );

  // decoded fields: lang R4, exp_user R5, aux R9, client R10, tool R11
  assign cfg_r = front_cfg_pkg::cfg_s'(sw_cap); // R4 R5 R9 R10 R11

  xfer_seq u_xfer (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(cfg_valid_r),
    .auto_xfer(cfg_r.auto_xfer),
    .exp_user(cfg_r.exp_user),
    .xfer_ack(xfer_ack),
    .xfer_req_r(xfer_req_r),
    .xfer_seg_r(xfer_seg_r),
    .exp_default_r(exp_default_r),
    .done_r(xfer_done)
  );

  // ************************************************
  // programming device write gate
  // ************************************************
  function automatic logic guarded(input front_cfg_pkg::area_e a);
    guarded = (a != front_cfg_pkg::AREA_OTHER);
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd_wr_ok_r <= 1'b0;
      pd_wr_rej_r <= 1'b0;
    end else begin
      // writes before capture are refused as if protected
      pd_wr_rej_r <= pd_wr_req && guarded(pd_wr_area) &&
                     (cfg_r.write_protect || !cfg_valid_r); // R1
      pd_wr_ok_r <= pd_wr_req && !(guarded(pd_wr_area) &&
                    (cfg_r.write_protect || !cfg_valid_r)); // R1
    end
  end

  // ************************************************
  // serial port settings
  // ************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_r <= '0;
      rs232_r <= '0;
    end else begin
      rs232_r.std <= cfg_r.port_std; // R6
      rs232_r.setup_base <= cfg_r.port_std ? front_cfg_pkg::SETUP_NONE :
                            front_cfg_pkg::SETUP_RS232_BASE; // R8
      periph_r.std <= cfg_r.port_std && cfg_r.periph_other; // R6 R7
      periph_r.setup_base <= (cfg_r.port_std && cfg_r.periph_other) ?
                             front_cfg_pkg::SETUP_NONE :
                             front_cfg_pkg::SETUP_PERIPH_BASE; // R7 R8
    end
  end

  // ************************************************
  // battery and retention
  // ************************************************
  assign batt_err_nxt = batt_expired &&
    (setup_r[front_cfg_pkg::BATT_CODE_LSB +: front_cfg_pkg::BATT_CODE_W] != BATT_OFF_CODE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      batt_err_r <= 1'b0;
    end else begin
      batt_err_r <= batt_err_nxt; // R12
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      retain_clear_r <= 1'b0;
      special_undef_r <= 1'b0;
    end else begin
      retain_clear_r <= pwr_off && batt_expired; // R13
      if (pwr_off && batt_expired) begin
        special_undef_r <= 1'b1; // R13
      end
    end
  end

  // ************************************************
  // hold bit and fatal stop
  // ************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_clear_r <= 1'b0;
      outputs_off_r <= 1'b0;
    end else begin
      io_clear_r <= mode_change && !io_hold; // R16
      outputs_off_r <= fatal_stop; // R16
    end
  end

  // ************************************************
  // AHB-Lite slave
  // ************************************************
  function automatic logic [31:0] read_mux(input logic [AW-1:0] a);
    read_mux = 32'h0000_0000;
    case (a)
      front_cfg_pkg::OFS_SWITCH: read_mux = {23'h0, cfg_valid_r, sw_cap};
      front_cfg_pkg::OFS_PORT: read_mux = {29'h0, cfg_r.periph_other, rs232_r.std, periph_r.std};
      front_cfg_pkg::OFS_SETUP: read_mux = {16'h0, setup_r};
      front_cfg_pkg::OFS_STATE: read_mux = {27'h0, outputs_off_r, io_hold,
                                            special_undef_r, batt_err_r, xfer_req_r};
      front_cfg_pkg::OFS_IRQ_STAT: read_mux = {28'h0, irq_stat_r};
      front_cfg_pkg::OFS_IRQ_MASK: read_mux = {28'h0, irq_mask_r};
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction

  assign addr_ok = hsel && hready && htrans[1] && (haddr[31:AW] == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[AW-1:0];
      hrdata <= (addr_ok && !hwrite) ? read_mux(haddr[AW-1:0]) : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setup_r <= front_cfg_pkg::SETUP_RST;
      irq_mask_r <= '0;
    end else if (wr_pend_r) begin
      if (wr_addr_r == front_cfg_pkg::OFS_SETUP) begin
        setup_r <= hwdata[front_cfg_pkg::SETUP_W-1:0];
      end
      if (wr_addr_r == front_cfg_pkg::OFS_IRQ_MASK) begin
        irq_mask_r <= hwdata[front_cfg_pkg::IRQ_W-1:0];
      end
    end
  end

  // ************************************************
  // interrupts
  // ************************************************
  assign irq_ev = {retain_clear_r, batt_err_nxt && !batt_err_r, xfer_done, pd_wr_rej_r};
  assign irq_clr = (wr_pend_r && wr_addr_r == front_cfg_pkg::OFS_IRQ_STAT) ?
                   hwdata[front_cfg_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      // a new event beats a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      irq_r <= |(((irq_stat_r & ~irq_clr) | irq_ev) & irq_mask_r);
    end
  end

  // ************************************************
  // checks
  // ************************************************
  sequence s_dead_poweroff;
    pwr_off && batt_expired;
  endsequence

  sequence s_retained_lost;
    retain_clear_r ##1 special_undef_r [*2];
  endsequence

  a_wr_protect: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    pd_wr_req && guarded(pd_wr_area) && cfg_r.write_protect |=> pd_wr_rej_r && !pd_wr_ok_r)
    else $error("protected area write not rejected");

  a_wr_open: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    pd_wr_req && cfg_valid_r && !cfg_r.write_protect |=> pd_wr_ok_r && !pd_wr_rej_r)
    else $error("write refused with protection off");

  // capture edge takes the pin level seen two edges earlier, through the synchroniser
  a_lang_select: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    $rose(cfg_valid_r) |-> cfg_r.lang_english == $past(sw[2], 3))
    else $error("language select not from switch 3");

  a_exp_restore: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    $rose(cfg_valid_r) && !cfg_r.exp_user |=> exp_default_r)
    else $error("defaults not restored with switch 4 off");

  a_port_std: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    cfg_r.port_std |=> rs232_r.std && rs232_r.setup_base == front_cfg_pkg::SETUP_NONE)
    else $error("rs232 port not standard with switch 5 on");

  a_periph_ignore: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    !cfg_r.periph_other |=> !periph_r.std &&
      periph_r.setup_base == front_cfg_pkg::SETUP_PERIPH_BASE)
    else $error("switch 5 applied to console-only peripheral port");

  a_setup_ports: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    !cfg_r.port_std |=> rs232_r.setup_base == front_cfg_pkg::SETUP_RS232_BASE)
    else $error("rs232 port not set from setup words");

  a_aux_mirror: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    $rose(cfg_valid_r) |-> cfg_r.aux_0712 == $past(sw[5], 3))
    else $error("auxiliary bit 0712 differs from switch 6");

  a_batt_mask: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    setup_r[15:12] == BATT_OFF_CODE && $stable(setup_r) |=> !batt_err_r)
    else $error("battery error shown although masked");

  a_retain_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    s_dead_poweroff |=> s_retained_lost)
    else $error("retained data not cleared on dead battery power-off");

  a_hold_keep: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    mode_change && io_hold |=> !io_clear_r)
    else $error("memory cleared while hold bit set");

  a_fatal_off: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    fatal_stop |=> outputs_off_r)
    else $error("outputs not forced off on fatal stop");

endmodule
`default_nettype wire

// ==== common/front_cfg_pkg.sv ====
// Purpose: shared constants and types of the front switch configuration decoder
// Assumes: eight switches, switch 1 on bit 0
// Notes: register offsets are byte addresses on the AHB-Lite bus
package front_cfg_pkg;

  // ************************************************
  // register map
  // ************************************************
  localparam logic [7:0] OFS_SWITCH = 8'h00;
  localparam logic [7:0] OFS_PORT = 8'h04;
  localparam logic [7:0] OFS_SETUP = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam int ADDR_LSB_W = 8;

  localparam int SW_W = 8;
  localparam int SETUP_W = 16;
  localparam logic [SETUP_W-1:0] SETUP_RST = 16'h0000;
  localparam int BATT_CODE_LSB = 12;
  localparam int BATT_CODE_W = 4;

  // ************************************************
  // interrupt bits
  // ************************************************
  localparam int IRQ_W = 4;
  localparam int IRQ_WR_REJ = 0;
  localparam int IRQ_XFER_DONE = 1;
  localparam int IRQ_BATT = 2;
  localparam int IRQ_LOST = 3;

  // ************************************************
  // port settings
  // ************************************************
  localparam logic [12:0] SETUP_PERIPH_BASE = 13'd6650;
  localparam logic [12:0] SETUP_RS232_BASE = 13'd6645;
  localparam logic [12:0] SETUP_NONE = 13'd0;
  localparam logic [3:0] STD_DATA_BITS = 4'h7;
  localparam logic [1:0] STD_STOP_BITS = 2'h2;
  localparam logic STD_PARITY_EVEN = 1'b1;
  localparam logic [16:0] STD_BAUD = 17'd9600;

  // ************************************************
  // types
  // ************************************************
  // field order matches switch bits, switch 1 in the lsb
  typedef struct packed {
    logic proto_tool;
    logic periph_other;
    logic aux_0712;
    logic port_std;
    logic exp_user;
    logic lang_english;
    logic auto_xfer;
    logic write_protect;
  } cfg_s;

  typedef struct packed {
    logic std;
    logic [12:0] setup_base;
  } port_s;

  typedef enum logic [1:0] {
    AREA_PROGRAM = 2'h0,
    AREA_RODATA = 2'h1,
    AREA_SETUP = 2'h2,
    AREA_OTHER = 2'h3
  } area_e;

  typedef enum logic [1:0] {
    SEG_PROGRAM = 2'h0,
    SEG_RODATA = 2'h1,
    SEG_SETUP = 2'h2,
    SEG_EXPINFO = 2'h3
  } seg_e;

  typedef enum logic [2:0] {
    XS_IDLE = 3'b001,
    XS_REQ = 3'b010,
    XS_DONE = 3'b100
  } xfer_state_e;

endpackage

// ==== rtl/sw_sampler.sv ====
// Purpose: synchronise the front switches and capture them once after reset
// Assumes: switches are static levels during the settle window
// Notes: captured value holds until the next reset
`timescale 1ns/10ps
`default_nettype none
module sw_sampler #(
  parameter int W = 8,
  parameter int SETTLE = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] sw_in,
  output logic [W-1:0] sw_out_r,
  output logic valid_r
);

  localparam int CW = $clog2(SETTLE + 1);
  localparam logic [CW-1:0] CNT_END = CW'(SETTLE);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [CW-1:0] cnt_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= sw_in;
      sync_r <= meta_r;
    end
  end

  // single capture after the settle count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
      valid_r <= 1'b0;
      sw_out_r <= '0;
    end else if (!valid_r) begin // R17
      if (cnt_r == CNT_END) begin
        valid_r <= 1'b1;
        sw_out_r <= sync_r;
      end else begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

  a_sample_held: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    $past(valid_r) |-> valid_r && $stable(sw_out_r))
    else $error("switch settings changed after capture");

endmodule
`default_nettype wire

// ==== rtl/xfer_seq.sv ====
// Purpose: startup copy sequence from the memory cassette
// Assumes: loader answers each segment request with a one-cycle ack
// Notes: segment order program, read-only data, setup, expansion info
`timescale 1ns/10ps
`default_nettype none
module xfer_seq (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic auto_xfer,
  input wire logic exp_user,
  input wire logic xfer_ack,
  output logic xfer_req_r,
  output front_cfg_pkg::seg_e xfer_seg_r,
  output logic exp_default_r,
  output logic done_r
);

  front_cfg_pkg::xfer_state_e state_r;
  logic started_r;

  // ************************************************
  // sequencer
  // ************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= front_cfg_pkg::XS_IDLE;
      started_r <= 1'b0;
      xfer_req_r <= 1'b0;
      xfer_seg_r <= front_cfg_pkg::SEG_PROGRAM;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        front_cfg_pkg::XS_IDLE: begin
          if (start && !started_r) begin
            started_r <= 1'b1;
            if (auto_xfer) begin // R2
              state_r <= front_cfg_pkg::XS_REQ;
              xfer_req_r <= 1'b1;
              xfer_seg_r <= front_cfg_pkg::SEG_PROGRAM;
            end
          end
        end
        front_cfg_pkg::XS_REQ: begin
          if (xfer_ack) begin
            // expansion info is skipped when defaults are in force
            if (xfer_seg_r == front_cfg_pkg::SEG_EXPINFO ||
                (xfer_seg_r == front_cfg_pkg::SEG_SETUP && !exp_user)) begin // R3
              state_r <= front_cfg_pkg::XS_DONE;
              xfer_req_r <= 1'b0;
            end else begin
              xfer_seg_r <= front_cfg_pkg::seg_e'(xfer_seg_r + 2'h1);
            end
          end
        end
        front_cfg_pkg::XS_DONE: begin
          done_r <= 1'b1;
          state_r <= front_cfg_pkg::XS_IDLE;
        end
        default: begin
          state_r <= front_cfg_pkg::XS_IDLE;
          xfer_req_r <= 1'b0;
        end
      endcase
    end
  end

  // defaults restored once at startup whenever user codes are off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exp_default_r <= 1'b0;
    end else begin
      exp_default_r <= start && !started_r && !exp_user; // R3 R5
    end
  end

  a_skip_expinfo: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    xfer_req_r && !exp_user |-> xfer_seg_r != front_cfg_pkg::SEG_EXPINFO)
    else $error("expansion info requested while defaults selected");

  a_no_auto_copy: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    start && !started_r && !auto_xfer |=> !xfer_req_r [*3])
    else $error("cassette copy requested with auto transfer off");

endmodule
`default_nettype wire

// ==== tb/cassette_loader.sv ====
// Purpose: memory cassette loader model answering segment copy requests
// Assumes: a request stands until its one-cycle acknowledge
// Notes: slow waits three cycles before each acknowledge
`timescale 1ns/10ps
`default_nettype none
module cassette_loader (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic xfer_req_r,
  input wire front_cfg_pkg::seg_e xfer_seg_r,
  output logic xfer_ack,
  output logic bad,
  output int segs
);
  // ********
  // answer logic
  // ********
  logic [3:0] wait_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_ack <= 1'b0;
      bad <= 1'b0;
      wait_r <= 4'h0;
      segs <= 0;
    end else if (xfer_ack) begin
      xfer_ack <= 1'b0;
    end else if (xfer_req_r && wait_r >= (slow ? 4'h3 : 4'h0)) begin
      xfer_ack <= 1'b1;
      wait_r <= 4'h0;
      segs <= segs + 1;
      // segments must arrive in program, data, setup, expansion order
      if (xfer_seg_r !== front_cfg_pkg::seg_e'(segs[1:0])) begin
        bad <= 1'b1;
      end
    end else if (xfer_req_r) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench of the front switch configuration decoder
// Assumes: zero wait state slave, short settle window
// Notes: each switch pattern but 8'hc0 is applied through a fresh reset
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ********
  // design and partner
  // ********
  localparam logic [3:0] BOFF = 4'h1;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, cfg_valid_r, pd_wr_ok_r, pd_wr_rej_r, xfer_ack;
  logic xfer_req_r, exp_default_r, batt_err_r, retain_clear_r, special_undef_r;
  logic io_clear_r, outputs_off_r, irq_r, bad;
  logic [31:0] hrdata;
  logic [7:0] sw = 8'h00;
  logic pd_wr_req = 1'b0;
  logic [1:0] area = 2'h0;
  logic batt_expired = 1'b0;
  logic pwr_off = 1'b0;
  logic mode_change = 1'b0;
  logic fatal_stop = 1'b0;
  logic io_hold = 1'b0;
  logic slow = 1'b0;
  front_cfg_pkg::cfg_s cfg_r;
  front_cfg_pkg::seg_e xfer_seg_r;
  front_cfg_pkg::port_s periph_r, rs232_r;
  int segs, n_exp, n_ret, n_ioc;
  int fails = 0;
  int comparisons = 0;

  always #12.5 hclk = ~hclk;
  assign hready = hreadyout;

  front_switch_config_decoder #(.SETTLE_CYCLES(2), .BATT_OFF_CODE(BOFF))
    i_front_switch_config_decoder (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sw(sw),
    .pd_wr_req(pd_wr_req), .pd_wr_area(front_cfg_pkg::area_e'(area)),
    .xfer_ack(xfer_ack), .batt_expired(batt_expired), .pwr_off(pwr_off),
    .mode_change(mode_change), .fatal_stop(fatal_stop), .io_hold(io_hold),
    .cfg_r(cfg_r), .cfg_valid_r(cfg_valid_r), .pd_wr_ok_r(pd_wr_ok_r),
    .pd_wr_rej_r(pd_wr_rej_r), .xfer_req_r(xfer_req_r), .xfer_seg_r(xfer_seg_r),
    .exp_default_r(exp_default_r), .periph_r(periph_r), .rs232_r(rs232_r),
    .batt_err_r(batt_err_r), .retain_clear_r(retain_clear_r),
    .special_undef_r(special_undef_r), .io_clear_r(io_clear_r),
    .outputs_off_r(outputs_off_r), .irq_r(irq_r));

  cassette_loader i_cassette_loader (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .xfer_req_r(xfer_req_r), .xfer_seg_r(xfer_seg_r), .xfer_ack(xfer_ack), .bad(bad),
    .segs(segs));

  // pulse counters, cleared by every reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_exp <= 0;
      n_ret <= 0;
      n_ioc <= 0;
    end else begin
      n_exp <= n_exp + int'(exp_default_r);
      n_ret <= n_ret + int'(retain_clear_r);
      n_ioc <= n_ioc + int'(io_clear_r);
    end
  end

  // ********
  // shared tasks
  // ********
  task test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task expire(input logic ok);
    if (!ok) begin
      fails++;
      $display("ERROR at %0t: wait ran out", $time);
      test_done;
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask

  task wait_rdy(output logic [31:0] rd);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 20 && seen !== 1'b1; i++) begin
      @(negedge hclk);
      seen = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end
    expire(seen === 1'b1);
  endtask

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask

  task pdw(input logic [1:0] a, input logic [1:0] exp);
    @(posedge hclk);
    pd_wr_req <= 1'b1;
    area <= a;
    @(posedge hclk);
    pd_wr_req <= 1'b0;
    @(negedge hclk);
    chk({pd_wr_ok_r, pd_wr_rej_r}, exp);
  endtask

  task pulse(input logic p, input logic m);
    @(posedge hclk);
    pwr_off <= p;
    mode_change <= m;
    @(posedge hclk);
    pwr_off <= 1'b0;
    mode_change <= 1'b0;
    tick(2);
  endtask

  // reset with a switch pattern, wait for capture and any cassette copy
  task boot(input logic [7:0] v, input logic s);
    int i;
    @(posedge hclk);
    hresetn <= 1'b0;
    sw <= v;
    slow <= s;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 40 && cfg_valid_r !== 1'b1; i++) @(negedge hclk);
    expire(cfg_valid_r === 1'b1);
    chk(cfg_r, {24'h0, v});
    for (i = 0; i < 200 && (i < 3 || xfer_req_r !== 1'b0); i++) @(negedge hclk);
    expire(xfer_req_r === 1'b0);
    tick(3);
    chk(bad, 1'b0);
  endtask

  // ********
  // scenarios
  // ********
  task t_protect_copy;
    boot(8'h3f, 1'b1);
    chk(segs, 4);
    chk(n_exp, 0);
    chk(periph_r, {1'b0, front_cfg_pkg::SETUP_PERIPH_BASE});
    chk(rs232_r, {1'b1, front_cfg_pkg::SETUP_NONE});
    rdchk(front_cfg_pkg::OFS_PORT, 32'h2);
    rdchk(front_cfg_pkg::OFS_IRQ_STAT, 32'h2);
    for (int a = 0; a < 4; a++) pdw(a[1:0], a == 3 ? 2'b10 : 2'b01);
    @(posedge hclk);
    sw <= 8'hc0;
    tick(4);
    chk(cfg_r, 32'h3f);
    rdchk(front_cfg_pkg::OFS_SWITCH, 32'h13f);
  endtask

  task t_defaults;
    boot(8'h42, 1'b0);
    chk(segs, 3);
    chk(n_exp, 1);
    chk(periph_r, {1'b0, front_cfg_pkg::SETUP_PERIPH_BASE});
    chk(rs232_r, {1'b0, front_cfg_pkg::SETUP_RS232_BASE});
    for (int a = 0; a < 4; a++) pdw(a[1:0], 2'b10);
  endtask

  task t_standard;
    boot(8'hd0, 1'b0);
    chk(segs, 0);
    chk(periph_r, {1'b1, front_cfg_pkg::SETUP_NONE});
    chk(rs232_r, {1'b1, front_cfg_pkg::SETUP_NONE});
    rdchk(front_cfg_pkg::OFS_PORT, 32'h7);
    pdw(2'h0, 2'b10);
  endtask

  task t_battery;
    rdchk(front_cfg_pkg::OFS_SETUP, 32'h0);
    wr(front_cfg_pkg::OFS_SETUP, {16'h0, BOFF, 12'h000});
    @(posedge hclk);
    batt_expired <= 1'b1;
    tick(3);
    chk(batt_err_r, 1'b0);
    wr(front_cfg_pkg::OFS_SETUP, 32'h0);
    tick(3);
    chk(batt_err_r, 1'b1);
    chk(irq_r, 1'b0);
    wr(front_cfg_pkg::OFS_IRQ_MASK, 32'h4);
    tick(3);
    chk(irq_r, 1'b1);
    wr(front_cfg_pkg::OFS_IRQ_STAT, 32'h4);
    tick(3);
    chk(irq_r, 1'b0);
    rdchk(front_cfg_pkg::OFS_IRQ_STAT, 32'h0);
    pulse(1'b1, 1'b0);
    chk(n_ret, 1);
    chk(special_undef_r, 1'b1);
    rdchk(front_cfg_pkg::OFS_IRQ_STAT, 32'h8);
    @(posedge hclk);
    io_hold <= 1'b1;
    pulse(1'b0, 1'b1);
    chk(n_ioc, 0);
    @(posedge hclk);
    io_hold <= 1'b0;
    pulse(1'b0, 1'b1);
    chk(n_ioc, 1);
    @(posedge hclk);
    fatal_stop <= 1'b1;
    tick(2);
    chk(outputs_off_r, 1'b1);
    rdchk(front_cfg_pkg::OFS_STATE, 32'h16);
    wr(front_cfg_pkg::OFS_SWITCH, 32'hff);
    rdchk(front_cfg_pkg::OFS_SWITCH, 32'h1d0);
    rdchk(8'h40, 32'h0);
    chk(hresp, 1'b0);
  endtask

  initial begin
    t_protect_copy;
    t_defaults;
    t_standard;
    t_battery;
    test_done;
  end
endmodule
`default_nettype wire
